// file: hsr_pkg.sv
package hsr_pkg;

  // ---------------------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  HSR_CMD_OP_LIMIT   = 8'h6B;  // overpower_threshold
  localparam logic [7:0]  HSR_CMD_SUMMARY    = 8'h79;  // summary_status_word
  localparam logic [7:0]  HSR_CMD_IOUT       = 8'h7B;  // output_current_status
  localparam logic [7:0]  HSR_CMD_INPUT      = 8'h7C;  // input_supply_status

  // ---------------------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------------------
  localparam int          HSR_DATA_W         = 16;
  localparam int          HSR_PWR_W          = 15;
  localparam int          HSR_SYNC_W         = 4;
  localparam logic [14:0] HSR_OP_LIMIT_RST   = 15'h7FFF;
  localparam logic [15:0] HSR_SUMMARY_RST    = 16'h0000;
  localparam logic [7:0]  HSR_STAT8_RST      = 8'h00;

  // ---------------------------------------------------------------------------
  // summary word field positions
  // ---------------------------------------------------------------------------
  localparam int          HSR_SW_CURRENT_BIT = 14;
  localparam int          HSR_SW_INPUT_BIT   = 13;
  localparam int          HSR_SW_VENDOR_BIT  = 12;
  localparam int          HSR_SW_PGOOD_BIT   = 11;
  localparam int          HSR_SW_BYTE_MSB    = 7;

  // ---------------------------------------------------------------------------
  // output-current status field positions
  // ---------------------------------------------------------------------------
  localparam int          HSR_IO_TRIP_BIT    = 7;
  localparam int          HSR_IO_WARN_BIT    = 5;

  // ---------------------------------------------------------------------------
  // input-supply status field positions
  // ---------------------------------------------------------------------------
  localparam int          HSR_IN_OVPIN_BIT   = 7;
  localparam int          HSR_IN_OVWARN_BIT  = 6;
  localparam int          HSR_IN_UVWARN_BIT  = 5;
  localparam int          HSR_IN_UVPIN_BIT   = 4;
  localparam int          HSR_IN_OPWARN_BIT  = 0;

  // ---------------------------------------------------------------------------
  // positions of the pin comparators inside the synchroniser vector
  // ---------------------------------------------------------------------------
  localparam int          HSR_PIN_TRIP       = 0;
  localparam int          HSR_PIN_OV         = 1;
  localparam int          HSR_PIN_UV         = 2;
  localparam int          HSR_PIN_FET_BAD    = 3;

  // asynchronous comparator and fault levels from the analog side
  typedef struct packed {
    logic overcurrent_trip;                 // timer elapsed, gate shut down
    logic overvoltage_sense_input;          // overvoltage pin comparator
    logic undervoltage_sense_inputs;        // undervoltage pin comparator
    logic fet_sense_a;                      // fet_sense_a comparison: power bad
  } hsr_pins_t;

  // power monitor limit comparisons, same clock domain
  typedef struct packed {
    logic                  overcurrent_warning;
    logic                  overvoltage_warning;
    logic                  undervoltage_warning;
    logic                  pwr_valid;       // one-cycle new power sample
    logic [HSR_PWR_W-1:0]  pwr_code;        // power in adc codes
  } hsr_mon_t;

  // command port request
  typedef struct packed {
    logic                   rd_en;
    logic                   wr_en;
    logic                   clear_faults;
    logic [7:0]             cmd;
    logic [HSR_DATA_W-1:0]  wr_data;
  } hsr_req_t;

endpackage

// file: hsr_sync.sv
`timescale 1ns/1ps
module hsr_sync
  import hsr_pkg::*;
#(
  parameter int W = HSR_SYNC_W
)
(
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          ce,
  // levels
  input  wire logic [W-1:0]  async_in,
  output logic      [W-1:0]  sync_out
);

  // ---------------------------------------------------------------------------
  // two-stage synchroniser per bit
  // ---------------------------------------------------------------------------
  // first stage is read only by the second one, to contain metastability
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    logic meta_q;
    logic stab_q;
    always_ff @(posedge clk_sys)
    begin
      if (!rst_b)
      begin
        meta_q <= 1'b0;
        stab_q <= 1'b0;
      end
      else if (ce)
      begin
        meta_q <= async_in[i];
        stab_q <= meta_q;
      end
    end
    assign sync_out[i] = stab_q;
  end

endmodule // hsr_sync

// file: hsr_status_regs.sv
`timescale 1ns/1ps
// Summary of operation
// R1: reserved bits always read as zero
// R2: summary bit 14 live current-status pending
// R3: summary bit 13 live input-status pending
// R4: summary bit 12 live vendor-status pending
// R5: summary bit 11 inverse of power good
// R6: summary low byte mirrors status byte
// R7: current bit 7 latches overcurrent trip
// R8: current bit 5 latches overcurrent warning
// R9: input bit 7 latches overvoltage pin
// R10: input bit 6 latches overvoltage warning
// R11: input bit 5 latches undervoltage warning
// R12: input bit 4 latches undervoltage pin
// R13: input bit 0 latches overpower warning
// R14: all three registers reset to zero
// R15: overpower compare against 15-bit threshold, reset max
// R16: latched bits hold until clear command
// R17: writes to status registers change nothing
module hsr_status_regs
  import hsr_pkg::*;
#(
  parameter int PWR_W = HSR_PWR_W
)
(
  // clock, reset, enable
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  input  wire logic                   ce,
  // event sources
  input  hsr_pins_t                   pins,
  input  hsr_mon_t                    mon,
  input  wire logic [7:0]             status_byte,
  input  wire logic [7:0]             vendor_extra_status,
  // command port
  input  hsr_req_t                    req,
  output logic      [HSR_DATA_W-1:0]  rd_data_q,
  output logic                        rd_ack_q,
  output logic                        rd_unmapped_q,
  // status outputs
  output logic                        power_good_output_q,
  output logic                        trip_event_q
);

  // ---------------------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------------------
  logic [HSR_SYNC_W-1:0] pin_raw;
  logic [HSR_SYNC_W-1:0] pin_sync;

  assign pin_raw[HSR_PIN_TRIP]    = pins.overcurrent_trip;
  assign pin_raw[HSR_PIN_OV]      = pins.overvoltage_sense_input;
  assign pin_raw[HSR_PIN_UV]      = pins.undervoltage_sense_inputs;
  assign pin_raw[HSR_PIN_FET_BAD] = pins.fet_sense_a;

  hsr_sync #(
    .W        (HSR_SYNC_W)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .ce       (ce),
    .async_in (pin_raw),
    .sync_out (pin_sync)
  );

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [7:0]       iout_q;
  logic [7:0]       iout_d;
  logic [7:0]       input_q;
  logic [7:0]       input_d;
  logic [PWR_W-1:0] op_limit_q;
  logic [PWR_W-1:0] op_limit_d;
  logic             trip_prev_q;

  // ---------------------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------------------
  logic hit_summary;
  logic hit_iout;
  logic hit_input;
  logic hit_limit;
  logic hit_any;
  logic do_read;
  logic do_limit_wr;
  logic do_clear;

  assign hit_summary = (req.cmd == HSR_CMD_SUMMARY);
  assign hit_iout    = (req.cmd == HSR_CMD_IOUT);
  assign hit_input   = (req.cmd == HSR_CMD_INPUT);
  assign hit_limit   = (req.cmd == HSR_CMD_OP_LIMIT);
  assign hit_any     = hit_summary | hit_iout | hit_input | hit_limit;
  assign do_read     = ce & req.rd_en;
  // only the threshold takes writes; status codes drop them [R17]
  assign do_limit_wr = ce & req.wr_en & hit_limit;
  assign do_clear    = ce & req.clear_faults;

  // ---------------------------------------------------------------------------
  // event detection
  // ---------------------------------------------------------------------------
  logic set_trip;
  logic set_oc_warn;
  logic set_ov_pin;
  logic set_ov_warn;
  logic set_uv_warn;
  logic set_uv_pin;
  logic set_op_warn;
  logic trip_rise;

  assign set_trip    = pin_sync[HSR_PIN_TRIP];                   // [R7]
  assign set_oc_warn = mon.overcurrent_warning;                  // [R8]
  assign set_ov_pin  = pin_sync[HSR_PIN_OV];                     // [R9]
  assign set_ov_warn = mon.overvoltage_warning;                  // [R10]
  assign set_uv_warn = mon.undervoltage_warning;                 // [R11]
  assign set_uv_pin  = pin_sync[HSR_PIN_UV];                     // [R12]
  // strictly above the threshold, sampled only on a fresh reading
  assign set_op_warn = mon.pwr_valid & (mon.pwr_code > op_limit_q); // [R13] [R15]
  assign trip_rise   = pin_sync[HSR_PIN_TRIP] & ~trip_prev_q;

  // ---------------------------------------------------------------------------
  // next state of latched registers
  // ---------------------------------------------------------------------------
  // a clear and a set in one cycle keep the bit set, so no event is lost
  logic [7:0] iout_set;
  logic [7:0] input_set;
  logic [7:0] iout_keep;
  logic [7:0] input_keep;

  assign iout_set   = {set_trip, 1'b0, set_oc_warn, 5'h00};      // [R1] [R7] [R8]
  assign input_set  = {set_ov_pin, set_ov_warn, set_uv_warn, set_uv_pin,
                       3'h0, set_op_warn};                       // [R1]
  assign iout_keep  = do_clear ? 8'h00 : iout_q;                 // [R16]
  assign input_keep = do_clear ? 8'h00 : input_q;                // [R16]
  assign iout_d     = iout_keep | iout_set;
  assign input_d    = input_keep | input_set;
  assign op_limit_d = do_limit_wr ? req.wr_data[PWR_W-1:0] : op_limit_q;

  // ---------------------------------------------------------------------------
  // latched status registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      iout_q  <= HSR_STAT8_RST;                                  // [R14]
      input_q <= HSR_STAT8_RST;                                  // [R14]
    end
    else if (ce)
    begin
      iout_q  <= iout_d;                                         // [R16]
      input_q <= input_d;                                        // [R16]
    end
  end

  // ---------------------------------------------------------------------------
  // overpower threshold
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      op_limit_q <= HSR_OP_LIMIT_RST;                            // [R15]
    else
      op_limit_q <= op_limit_d;
  end

  // ---------------------------------------------------------------------------
  // live summary word
  // ---------------------------------------------------------------------------
  // live bits are built from present state at read time, never stored
  logic [HSR_DATA_W-1:0] summary;

  always_comb
  begin
    summary                                  = HSR_SUMMARY_RST; // [R1]
    summary[HSR_SW_CURRENT_BIT]              = |iout_q;          // [R2]
    summary[HSR_SW_INPUT_BIT]                = |input_q;         // [R3]
    summary[HSR_SW_VENDOR_BIT]               = |vendor_extra_status; // [R4]
    summary[HSR_SW_PGOOD_BIT]                = ~power_good_output_q; // [R5]
    summary[HSR_SW_BYTE_MSB:0]               = status_byte;      // [R6]
  end

  // ---------------------------------------------------------------------------
  // read data selection
  // ---------------------------------------------------------------------------
  logic [HSR_DATA_W-1:0] rd_sel;

  assign rd_sel = hit_summary ? summary :
                  hit_iout    ? {8'h00, iout_q} :
                  hit_input   ? {8'h00, input_q} :
                  hit_limit   ? {1'b0, op_limit_q} :
                  16'h0000;                                      // [R1]

  // ---------------------------------------------------------------------------
  // read answer
  // ---------------------------------------------------------------------------
  // answer one cycle after the request; unknown codes answer zero and flag
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rd_data_q     <= HSR_SUMMARY_RST;                          // [R14]
      rd_ack_q      <= 1'b0;
      rd_unmapped_q <= 1'b0;
    end
    else if (ce)
    begin
      rd_ack_q      <= do_read;
      rd_unmapped_q <= do_read & ~hit_any;
      if (do_read)
        rd_data_q <= rd_sel;
    end
  end

  // ---------------------------------------------------------------------------
  // power good and trip event outputs
  // ---------------------------------------------------------------------------
  // trip pulse lets the status byte set its own copy of the fault
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      power_good_output_q <= 1'b0;
      trip_prev_q         <= 1'b0;
      trip_event_q        <= 1'b0;
    end
    else if (ce)
    begin
      power_good_output_q <= ~pin_sync[HSR_PIN_FET_BAD];         // [R5]
      trip_prev_q         <= pin_sync[HSR_PIN_TRIP];
      trip_event_q        <= trip_rise;                          // [R7]
    end
  end

endmodule // hsr_status_regs

// file: hsr_status_regs_monitor.sv
`timescale 1ns/1ps
module hsr_status_regs_monitor
  import hsr_pkg::*;
(
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rst_b,
  input wire logic                   ce,
  // event sources
  input hsr_pins_t                   pins,
  input hsr_mon_t                    mon,
  input wire logic [7:0]             status_byte,
  input wire logic [7:0]             vendor_extra_status,
  // command port
  input hsr_req_t                    req,
  input wire logic [HSR_DATA_W-1:0]  rd_data_q,
  input wire logic                   rd_ack_q,
  input wire logic                   rd_unmapped_q,
  // status outputs
  input wire logic                   power_good_output_q,
  input wire logic                   trip_event_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // command seen at the edge that took the read being answered now
  logic [7:0] cmd_q;
  always_ff @(posedge clk_sys) cmd_q <= req.cmd;
  sequence s_sum;  rd_ack_q && cmd_q == HSR_CMD_SUMMARY; endsequence
  sequence s_iout; rd_ack_q && cmd_q == HSR_CMD_IOUT;    endsequence
  sequence s_inp;  rd_ack_q && cmd_q == HSR_CMD_INPUT;   endsequence
  // fet_sense_a comparator bad for three samples: sync plus register has landed
  sequence s_fet_bad; (ce && pins.fet_sense_a) [*3]; endsequence
  a_sum_reserved: assert property (s_sum |-> rd_data_q[15] == 1'b0 && rd_data_q[10:8] == 3'h0)
    else $error("summary reserved bits set");
  a_iout_reserved: assert property (s_iout |-> rd_data_q[15:8] == 8'h00
    && rd_data_q[6] == 1'b0 && rd_data_q[4:0] == 5'h00) else $error("current reserved bits set");
  a_input_reserved: assert property (s_inp |-> rd_data_q[15:8] == 8'h00
    && rd_data_q[3:1] == 3'h0) else $error("input reserved bits set");
  a_sum_byte: assert property (s_sum |-> rd_data_q[7:0] == $past(status_byte))
    else $error("summary low byte differs from status byte");
  a_sum_vendor: assert property (s_sum |-> rd_data_q[12] == |$past(vendor_extra_status))
    else $error("summary vendor bit wrong");
  a_sum_pgood: assert property (s_sum |-> rd_data_q[11] == !$past(power_good_output_q))
    else $error("summary power bit not inverse of power good");
  a_pgood_drop: assert property (s_fet_bad |=> !power_good_output_q)
    else $error("power good stays high with fet_sense_a bad");
  a_trip_pulse: assert property (trip_event_q |=> !trip_event_q)
    else $error("trip event longer than one cycle");
  a_reset_clean: assert property ($rose(rst_b) |-> !rd_ack_q && rd_data_q == 16'h0000)
    else $error("outputs not cleared by reset");
endmodule // hsr_status_regs_monitor

bind hsr_status_regs hsr_status_regs_monitor hsr_status_regs_monitor_i (.clk_sys(clk_sys),
  .rst_b(rst_b), .ce(ce), .pins(pins), .mon(mon), .status_byte(status_byte),
  .vendor_extra_status(vendor_extra_status), .req(req), .rd_data_q(rd_data_q),
  .rd_ack_q(rd_ack_q), .rd_unmapped_q(rd_unmapped_q),
  .power_good_output_q(power_good_output_q), .trip_event_q(trip_event_q));

// file: hsr_host_model.sv
`timescale 1ns/1ps
module hsr_host_model
  import hsr_pkg::*;
(
  // clock
  input wire logic                   clk_sys,
  // command port
  output hsr_req_t                   req,
  input wire logic [HSR_DATA_W-1:0]  rd_data_q,
  input wire logic                   rd_ack_q,
  input wire logic                   rd_unmapped_q
);
  initial req = '0;
  // one request held from a falling edge across the rising edge that takes it
  task automatic issue(input logic [2:0] kind, input logic [7:0] c, input logic [15:0] w);
    @(negedge clk_sys);
    {req.rd_en, req.wr_en, req.clear_faults} = kind;
    req.cmd = c;
    req.wr_data = w;
    @(negedge clk_sys);
    {req.rd_en, req.wr_en, req.clear_faults} = 3'h0;
    // idle fields wander so a stale command is never mistaken for a live one
    req.cmd = ~c;
    req.wr_data = ~w;
  endtask
  // answer stands only in the cycle after the taking edge
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic [1:0] f);
    issue(3'h4, c, 16'h0000);
    d = rd_data_q;
    f = {rd_ack_q, rd_unmapped_q};
  endtask
endmodule // hsr_host_model

// file: hsr_status_regs_tb_top.sv
`timescale 1ns/1ps
module hsr_status_regs_tb_top;
  import hsr_pkg::*;
  typedef struct packed {
    logic [3:0] pin;
    logic [2:0] warn;
    logic [7:0] io;
    logic [7:0] inp;
  } hsr_row_t;
  logic             clk_sys, rst_b, ce;
  hsr_pins_t        pins;
  hsr_mon_t         mon;
  logic [7:0]       status_byte, vendor_extra_status;
  hsr_req_t         req;
  logic [15:0]      rd_data_q, d;
  logic             rd_ack_q, rd_unmapped_q, power_good_output_q, trip_event_q;
  logic [1:0]       f;
  int               num_errors = 0, num_checks = 0, cycles = 0;
  int               trips = 0;
  // pins {trip, ov, uv, fet}, warnings {oc, ov, uv}, expected latched bytes
  hsr_row_t rows [7] = '{'{4'h8, 3'h0, 8'h80, 8'h00}, '{4'h4, 3'h0, 8'h00, 8'h80},
    '{4'h2, 3'h0, 8'h00, 8'h10}, '{4'h0, 3'h4, 8'h20, 8'h00}, '{4'h0, 3'h2, 8'h00, 8'h40},
    '{4'h0, 3'h1, 8'h00, 8'h20}, '{4'h0, 3'h0, 8'h00, 8'h00}};

  hsr_status_regs hsr_status_regs_i (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .pins(pins),
    .mon(mon), .status_byte(status_byte), .vendor_extra_status(vendor_extra_status),
    .req(req), .rd_data_q(rd_data_q), .rd_ack_q(rd_ack_q), .rd_unmapped_q(rd_unmapped_q),
    .power_good_output_q(power_good_output_q), .trip_event_q(trip_event_q));
  hsr_host_model hsr_host_model_i (.clk_sys(clk_sys), .req(req), .rd_data_q(rd_data_q),
    .rd_ack_q(rd_ack_q), .rd_unmapped_q(rd_unmapped_q));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // a hung handshake ends the run well past the expected run of under two hundred cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  // trip pulse counted at each edge that sees it high
  always @(posedge clk_sys)
  begin
    if (trip_event_q === 1'b1)
      trips++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [15:0] e, input logic u);
    hsr_host_model_i.rd(c, d, f);
    chk(d, e);
    chk({14'h0000, f}, {14'h0000, 1'b1, u});
  endtask
  task automatic pwr(input logic [14:0] c);
    @(negedge clk_sys);
    mon.pwr_valid = 1'b1;
    mon.pwr_code = c;
    @(negedge clk_sys);
    mon = '0;
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    pins = '0;
    mon = '0;
    status_byte = 8'h00;
    vendor_extra_status = 8'h00;
    repeat (16) @(negedge clk_sys);
    rst_b = 1'b1;
    // each source raised, dropped again, then read: bit must still be held
    foreach (rows[i])
    begin
      hsr_host_model_i.issue(3'h1, 8'h00, 16'h0000);
      pins = rows[i].pin;
      {mon.overcurrent_warning, mon.overvoltage_warning, mon.undervoltage_warning} = rows[i].warn;
      repeat (4) @(negedge clk_sys);
      pins = '0;
      mon = '0;
      repeat (4) @(negedge clk_sys);
      rdchk(HSR_CMD_IOUT, {8'h00, rows[i].io}, 1'b0);
      rdchk(HSR_CMD_INPUT, {8'h00, rows[i].inp}, 1'b0);
      rdchk(HSR_CMD_SUMMARY, {1'b0, |rows[i].io, |rows[i].inp, 13'h0000}, 1'b0);
    end
    // threshold keeps 15 bits; strictly above it sets the overpower bit
    hsr_host_model_i.issue(3'h2, HSR_CMD_OP_LIMIT, 16'hFFFF);
    rdchk(HSR_CMD_OP_LIMIT, 16'h7FFF, 1'b0);
    hsr_host_model_i.issue(3'h2, HSR_CMD_OP_LIMIT, 16'h0100);
    pwr(15'h0100);
    rdchk(HSR_CMD_INPUT, 16'h0000, 1'b0);
    pwr(15'h0101);
    rdchk(HSR_CMD_INPUT, 16'h0001, 1'b0);
    hsr_host_model_i.issue(3'h2, HSR_CMD_INPUT, 16'h0000);
    rdchk(HSR_CMD_INPUT, 16'h0001, 1'b0);
    // every live summary bit at once, then two of them fall away
    status_byte = 8'hA5;
    vendor_extra_status = 8'h40;
    pins.fet_sense_a = 1'b1;
    pins.overcurrent_trip = 1'b1;
    repeat (4) @(negedge clk_sys);
    rdchk(HSR_CMD_SUMMARY, 16'h78A5, 1'b0);
    pins.fet_sense_a = 1'b0;
    vendor_extra_status = 8'h00;
    repeat (4) @(negedge clk_sys);
    rdchk(HSR_CMD_SUMMARY, 16'h60A5, 1'b0);
    rdchk(8'h7A, 16'h0000, 1'b1);
    // enable low: an overvoltage pulse must not be captured
    pins = 4'h0;
    ce = 1'b0;
    pins = 4'h4;
    repeat (4) @(negedge clk_sys);
    pins = '0;
    ce = 1'b1;
    repeat (4) @(negedge clk_sys);
    rdchk(HSR_CMD_INPUT, 16'h0001, 1'b0);
    chk(trips[15:0], 16'h0002);
    // reset in mid-run wipes the latched bits and restores the threshold
    pins = '0;
    status_byte = 8'h00;
    rst_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    rdchk(HSR_CMD_SUMMARY, 16'h0000, 1'b0);
    rdchk(HSR_CMD_IOUT, 16'h0000, 1'b0);
    rdchk(HSR_CMD_INPUT, 16'h0000, 1'b0);
    rdchk(HSR_CMD_OP_LIMIT, 16'h7FFF, 1'b0);
    end_of_test();
  end
endmodule // hsr_status_regs_tb_top
